// File: include/spb_pkg.sv
// Constants and types for the paged register decoder
package spb_pkg;
	// ----------------------------------------
	// Addresses
	// ----------------------------------------
	localparam logic [7:0] ADDR_PORT0 = 8'h80;
	localparam logic [7:0] ADDR_SP = 8'h81;
	localparam logic [7:0] ADDR_SPCTL = 8'h85;
	localparam logic [7:0] ADDR_POWER_CONTROL_ZERO = 8'h87;
	localparam logic [7:0] ADDR_SYSTEM_FLAG_IRQ_ENABLE = 8'h8E;
	localparam logic [7:0] ADDR_PORT1 = 8'h90;
	localparam logic [7:0] ADDR_AIO = 8'h92;
	localparam logic [7:0] ADDR_MODE1 = 8'h93;
	localparam logic [7:0] ADDR_TCTL = 8'h95;
	localparam logic [7:0] ADDR_RSTEV = 8'h97;
	localparam logic [7:0] ADDR_UCTL = 8'h98;
	localparam logic [7:0] ADDR_UBUF = 8'h99;
	localparam logic [7:0] ADDR_PAGE = 8'hAC;
	// ----------------------------------------
	// Reset values and masks
	// ----------------------------------------
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_ONES = 8'hFF;
	localparam logic [7:0] RST_SP = 8'h07;
	localparam logic [7:0] RST_SPCTL = 8'h04;
	localparam logic [7:0] RST_POWER_CONTROL_ZERO = 8'h10;
	localparam logic [7:0] RST_SYSTEM_FLAG_IRQ_ENABLE = 8'h60;
	localparam logic [7:0] MASK_NO_BIT3 = 8'hF7;
	localparam logic [7:0] MASK_MODE1 = 8'h97;
	localparam logic [7:0] MASK_MODE1_T4 = 8'h9F;
	localparam logic [3:0] RST_PAGE = 4'h0;
	localparam int PAGE_W = 4;
	// ----------------------------------------
	// Pages
	// ----------------------------------------
	localparam logic [3:0] PG0 = 4'h0;
	localparam logic [3:0] PG1 = 4'h1;
	localparam logic [3:0] PG2 = 4'h2;
	localparam logic [3:0] PG3 = 4'h3;
	localparam logic [3:0] PG4 = 4'h4;
	// ----------------------------------------
	// Bus carrier
	// ----------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} spb_req_s;
	// Register selector
	typedef enum logic [4:0] {
		SEL_NONE, SEL_PAGE, SEL_P0, SEL_SP, SEL_SPCTL, SEL_POWER_CONTROL_ZERO, SEL_SYSTEM_FLAG_IRQ_ENABLE, SEL_P1,
		SEL_AIO1, SEL_AIO2, SEL_P0MODE, SEL_T2M1, SEL_T3M1, SEL_T4M1, SEL_P2MODE,
		SEL_TREN, SEL_TRLC, SEL_TSPC, SEL_RSTEV, SEL_U0C, SEL_U1C, SEL_U2C, SEL_U3C,
		SEL_U0B, SEL_U1B, SEL_U2B, SEL_U3B
	} spb_sel_e;
endpackage : spb_pkg

// File: rtl/spb_sfr_page_select_bank.sv
// Paged special-function-register decoder with register storage
module spb_sfr_page_select_bank (
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire spb_pkg::spb_req_s req_i,
	output logic [7:0] rdata_o,
	output logic [3:0] page_number_field_o,
	output logic [7:0] port_zero_latch_o,
	output logic [7:0] port_one_latch_o,
	output logic [7:0] stack_pointer_o,
	output logic [7:0] timer_run_enable_o
);
	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [spb_pkg::PAGE_W-1:0] page_number_field;
	logic [7:0] regs [spb_pkg::SEL_P0:spb_pkg::SEL_U3B];
	logic [7:0] rdata;
	spb_pkg::spb_sel_e sel;
	logic [spb_pkg::PAGE_W-1:0] next_page;
	logic [7:0] next_rdata;
	logic [7:0] wmask;

	// Decode compares against four-bit page codes
	if (spb_pkg::PAGE_W != 4) begin : g_bad_page_w
		$error("page index width must be four bits");
	end

	// ----------------------------------------
	// Address and page decode
	// ----------------------------------------
	always_comb begin
		sel = spb_pkg::SEL_NONE;
		unique case (req_i.addr)
			spb_pkg::ADDR_PAGE: sel = spb_pkg::SEL_PAGE;
			spb_pkg::ADDR_PORT0: sel = spb_pkg::SEL_P0;
			spb_pkg::ADDR_SP: sel = spb_pkg::SEL_SP;
			spb_pkg::ADDR_SPCTL: sel = spb_pkg::SEL_SPCTL;
			spb_pkg::ADDR_POWER_CONTROL_ZERO: sel = spb_pkg::SEL_POWER_CONTROL_ZERO;
			spb_pkg::ADDR_SYSTEM_FLAG_IRQ_ENABLE: sel = spb_pkg::SEL_SYSTEM_FLAG_IRQ_ENABLE;
			spb_pkg::ADDR_PORT1: sel = spb_pkg::SEL_P1;
			spb_pkg::ADDR_RSTEV: sel = spb_pkg::SEL_RSTEV;
			spb_pkg::ADDR_AIO: begin
				if (page_number_field == spb_pkg::PG0) sel = spb_pkg::SEL_AIO1;
				else if (page_number_field == spb_pkg::PG1) sel = spb_pkg::SEL_AIO2;
			end
			spb_pkg::ADDR_MODE1: begin
				unique case (page_number_field)
					spb_pkg::PG0: sel = spb_pkg::SEL_P0MODE;
					spb_pkg::PG1: sel = spb_pkg::SEL_T2M1;
					spb_pkg::PG2: sel = spb_pkg::SEL_T3M1;
					spb_pkg::PG3: sel = spb_pkg::SEL_T4M1;
					default: sel = spb_pkg::SEL_NONE;
				endcase
			end
			spb_pkg::ADDR_TCTL: begin
				unique case (page_number_field)
					spb_pkg::PG0: sel = spb_pkg::SEL_P2MODE;
					spb_pkg::PG1: sel = spb_pkg::SEL_TREN;
					spb_pkg::PG2: sel = spb_pkg::SEL_TRLC;
					spb_pkg::PG3: sel = spb_pkg::SEL_TSPC;
					default: sel = spb_pkg::SEL_NONE;
				endcase
			end
			spb_pkg::ADDR_UCTL: begin
				unique case (page_number_field)
					spb_pkg::PG0: sel = spb_pkg::SEL_U0C;
					spb_pkg::PG1, spb_pkg::PG2: sel = spb_pkg::SEL_U1C;
					spb_pkg::PG3: sel = spb_pkg::SEL_U2C;
					spb_pkg::PG4: sel = spb_pkg::SEL_U3C;
					default: sel = spb_pkg::SEL_NONE;
				endcase
			end
			spb_pkg::ADDR_UBUF: begin
				unique case (page_number_field)
					spb_pkg::PG0: sel = spb_pkg::SEL_U0B;
					spb_pkg::PG1, spb_pkg::PG2: sel = spb_pkg::SEL_U1B;
					spb_pkg::PG3: sel = spb_pkg::SEL_U2B;
					spb_pkg::PG4: sel = spb_pkg::SEL_U3B;
					default: sel = spb_pkg::SEL_NONE;
				endcase
			end
			default: sel = spb_pkg::SEL_NONE;
		endcase
	end

	// Unimplemented bits are held at zero
	always_comb begin
		unique case (sel)
			spb_pkg::SEL_SYSTEM_FLAG_IRQ_ENABLE, spb_pkg::SEL_RSTEV: wmask = spb_pkg::MASK_NO_BIT3;
			spb_pkg::SEL_T2M1, spb_pkg::SEL_T3M1: wmask = spb_pkg::MASK_MODE1;
			spb_pkg::SEL_T4M1: wmask = spb_pkg::MASK_MODE1_T4;
			default: wmask = spb_pkg::RST_ONES;
		endcase
	end

	// ----------------------------------------
	// Page index and read data
	// ----------------------------------------
	always_comb begin
		next_page = page_number_field;
		// Upper bits are dropped; the index is never stacked on interrupts
		if (req_i.wr && sel == spb_pkg::SEL_PAGE) begin
			next_page = req_i.wdata[spb_pkg::PAGE_W-1:0];
		end
		next_rdata = rdata;
		if (req_i.rd) begin
			if (sel == spb_pkg::SEL_PAGE) begin
				next_rdata = {4'h0, page_number_field};
			end else if (sel == spb_pkg::SEL_NONE) begin
				next_rdata = spb_pkg::RST_ZERO;
			end else begin
				next_rdata = regs[sel];
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			page_number_field <= spb_pkg::RST_PAGE;
			rdata <= spb_pkg::RST_ZERO;
		end else begin
			page_number_field <= next_page;
			rdata <= next_rdata;
		end
	end

	// ----------------------------------------
	// Register array
	// ----------------------------------------
	for (genvar g = spb_pkg::SEL_P0; g <= spb_pkg::SEL_U3B; g++) begin : g_reg
		logic [7:0] next_val;
		logic [7:0] rst_val;
		always_comb begin
			unique case (g)
				spb_pkg::SEL_P0, spb_pkg::SEL_P1: rst_val = spb_pkg::RST_ONES;
				spb_pkg::SEL_SP: rst_val = spb_pkg::RST_SP;
				spb_pkg::SEL_SPCTL: rst_val = spb_pkg::RST_SPCTL;
				spb_pkg::SEL_POWER_CONTROL_ZERO: rst_val = spb_pkg::RST_POWER_CONTROL_ZERO;
				spb_pkg::SEL_SYSTEM_FLAG_IRQ_ENABLE: rst_val = spb_pkg::RST_SYSTEM_FLAG_IRQ_ENABLE;
				default: rst_val = spb_pkg::RST_ZERO;
			endcase
			next_val = regs[g];
			if (req_i.wr && sel == spb_pkg::spb_sel_e'(g)) begin
				next_val = req_i.wdata & wmask;
			end
		end
		// Buffers keep no reset: contents undefined after reset
		if (g >= spb_pkg::SEL_U0B) begin : g_nrst
			always_ff @(posedge core_clk_i) begin
				regs[g] <= next_val;
			end
		end else begin : g_rst
			always_ff @(posedge core_clk_i) begin
				if (srst_i) begin
					regs[g] <= rst_val;
				end else begin
					regs[g] <= next_val;
				end
			end
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign rdata_o = rdata;
	assign page_number_field_o = page_number_field;
	assign port_zero_latch_o = regs[spb_pkg::SEL_P0];
	assign port_one_latch_o = regs[spb_pkg::SEL_P1];
	assign stack_pointer_o = regs[spb_pkg::SEL_SP];
	assign timer_run_enable_o = regs[spb_pkg::SEL_TREN];

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Bus shapes the core issues
	sequence s_page_wr(logic [3:0] p);
		req_i.wr && req_i.addr == spb_pkg::ADDR_PAGE && req_i.wdata[3:0] == p;
	endsequence

	sequence s_page_then_idle(logic [3:0] p);
		s_page_wr(p) ##1 !req_i.wr;
	endsequence

	sequence s_wr_at(logic [7:0] a);
		req_i.wr && req_i.addr == a;
	endsequence

	sequence s_wr_pg(logic [7:0] a, logic [3:0] p);
		req_i.wr && req_i.addr == a && page_number_field == p;
	endsequence

	sequence s_rd_at(logic [7:0] a);
		req_i.rd && !req_i.wr && req_i.addr == a;
	endsequence

	// Reset contents
	a_page_reset: assert property (@(posedge core_clk_i)
		srst_i |=> page_number_field_o == spb_pkg::RST_PAGE)
		else $error("page index not cleared by reset");
	a_sp_reset: assert property (@(posedge core_clk_i)
		srst_i |=> stack_pointer_o == spb_pkg::RST_SP)
		else $error("stack pointer reset wrong");
	a_port_reset: assert property (@(posedge core_clk_i)
		srst_i |=> port_zero_latch_o == spb_pkg::RST_ONES && port_one_latch_o == spb_pkg::RST_ONES)
		else $error("port latch reset wrong");
	a_spctl_reset: assert property (@(posedge core_clk_i)
		srst_i |=> regs[spb_pkg::SEL_SPCTL] == spb_pkg::RST_SPCTL)
		else $error("serial peripheral control reset wrong");
	a_power_control_zero_reset: assert property (@(posedge core_clk_i)
		srst_i |=> regs[spb_pkg::SEL_POWER_CONTROL_ZERO] == spb_pkg::RST_POWER_CONTROL_ZERO)
		else $error("power control zero reset wrong");
	a_system_flag_irq_enable_reset: assert property (@(posedge core_clk_i)
		srst_i |=> regs[spb_pkg::SEL_SYSTEM_FLAG_IRQ_ENABLE] == spb_pkg::RST_SYSTEM_FLAG_IRQ_ENABLE)
		else $error("flag enable reset wrong");
	a_rstev_reset: assert property (@(posedge core_clk_i)
		srst_i |=> regs[spb_pkg::SEL_RSTEV] == spb_pkg::RST_ZERO)
		else $error("reset event flags reset wrong");

	// Page index
	a_page_load: assert property (@(posedge core_clk_i) disable iff (srst_i)
		s_wr_at(spb_pkg::ADDR_PAGE) |=> page_number_field_o == $past(req_i.wdata[3:0]))
		else $error("page index not loaded");
	a_page_hold: assert property (@(posedge core_clk_i) disable iff (srst_i)
		!(req_i.wr && req_i.addr == spb_pkg::ADDR_PAGE) |=> $stable(page_number_field_o))
		else $error("page index changed without a write");
	a_page_read: assert property (@(posedge core_clk_i) disable iff (srst_i)
		s_rd_at(spb_pkg::ADDR_PAGE) |=> rdata_o == {4'h0, $past(page_number_field_o)})
		else $error("page index read back wrong");
	a_unmapped: assert property (@(posedge core_clk_i) disable iff (srst_i)
		s_rd_at(8'hA9) |=> rdata_o == spb_pkg::RST_ZERO)
		else $error("unmapped read nonzero");

	// Unpaged addresses
	a_sp_read: assert property (@(posedge core_clk_i) disable iff (srst_i)
		s_rd_at(spb_pkg::ADDR_SP) |=> rdata_o == $past(stack_pointer_o))
		else $error("stack pointer read wrong");
	a_power_control_zero_read: assert property (@(posedge core_clk_i) disable iff (srst_i)
		s_rd_at(spb_pkg::ADDR_POWER_CONTROL_ZERO) |=> rdata_o == $past(regs[spb_pkg::SEL_POWER_CONTROL_ZERO]))
		else $error("power control zero read wrong");
	a_p0_write: assert property (@(posedge core_clk_i) disable iff (srst_i)
		s_wr_at(spb_pkg::ADDR_PORT0) |=> port_zero_latch_o == $past(req_i.wdata))
		else $error("port zero latch not written");
	a_p1_write: assert property (@(posedge core_clk_i) disable iff (srst_i)
		s_wr_at(spb_pkg::ADDR_PORT1) |=> port_one_latch_o == $past(req_i.wdata))
		else $error("port one latch not written");
	a_system_flag_irq_enable_bit3: assert property (@(posedge core_clk_i) disable iff (srst_i)
		s_wr_at(spb_pkg::ADDR_SYSTEM_FLAG_IRQ_ENABLE) |=> regs[spb_pkg::SEL_SYSTEM_FLAG_IRQ_ENABLE][3] == 1'b0)
		else $error("flag enable bit 3 set");
	a_rstev_bit3: assert property (@(posedge core_clk_i) disable iff (srst_i)
		s_wr_at(spb_pkg::ADDR_RSTEV) |=> regs[spb_pkg::SEL_RSTEV][3] == 1'b0)
		else $error("reset event flags bit 3 set");

	// Paged addresses
	a_uart_zero: assert property (@(posedge core_clk_i) disable iff (srst_i)
		s_wr_pg(spb_pkg::ADDR_UCTL, spb_pkg::PG0) |=> regs[spb_pkg::SEL_U0C] == $past(req_i.wdata))
		else $error("uart zero control not written on page 0");
	a_uart_alias: assert property (@(posedge core_clk_i) disable iff (srst_i)
		s_wr_pg(spb_pkg::ADDR_UCTL, spb_pkg::PG2) |=> regs[spb_pkg::SEL_U1C] == $past(req_i.wdata))
		else $error("uart one control not written on page 2");
	a_uart_two: assert property (@(posedge core_clk_i) disable iff (srst_i)
		s_wr_pg(spb_pkg::ADDR_UCTL, spb_pkg::PG3) |=> regs[spb_pkg::SEL_U2C] == $past(req_i.wdata))
		else $error("uart two control not written on page 3");
	a_uart_three: assert property (@(posedge core_clk_i) disable iff (srst_i)
		s_wr_pg(spb_pkg::ADDR_UCTL, spb_pkg::PG4) |=> regs[spb_pkg::SEL_U3C] == $past(req_i.wdata))
		else $error("uart three control not written on page 4");
	a_ubuf_write: assert property (@(posedge core_clk_i) disable iff (srst_i)
		s_wr_pg(spb_pkg::ADDR_UBUF, spb_pkg::PG3) |=> regs[spb_pkg::SEL_U2B] == $past(req_i.wdata))
		else $error("uart two buffer not written on page 3");
	a_tren_page: assert property (@(posedge core_clk_i) disable iff (srst_i)
		s_page_then_idle(4'h1) ##1 s_wr_at(spb_pkg::ADDR_TCTL) |=> timer_run_enable_o == $past(req_i.wdata))
		else $error("timer run enable not written on page 1");
	a_tren_hold: assert property (@(posedge core_clk_i) disable iff (srst_i)
		page_number_field_o != spb_pkg::PG1 |=> $stable(timer_run_enable_o))
		else $error("timer run enable changed off page 1");
	a_trlc_page: assert property (@(posedge core_clk_i) disable iff (srst_i)
		s_wr_pg(spb_pkg::ADDR_TCTL, spb_pkg::PG2) |=> regs[spb_pkg::SEL_TRLC] == $past(req_i.wdata))
		else $error("timer reload control not written on page 2");
	a_tspc_page: assert property (@(posedge core_clk_i) disable iff (srst_i)
		s_wr_pg(spb_pkg::ADDR_TCTL, spb_pkg::PG3) |=> regs[spb_pkg::SEL_TSPC] == $past(req_i.wdata))
		else $error("timer stop control not written on page 3");
	a_aio_first: assert property (@(posedge core_clk_i) disable iff (srst_i)
		s_wr_pg(spb_pkg::ADDR_AIO, spb_pkg::PG0) |=> regs[spb_pkg::SEL_AIO1] == $past(req_i.wdata))
		else $error("port one analog only not written on page 0");
	a_aio_second: assert property (@(posedge core_clk_i) disable iff (srst_i)
		s_wr_pg(spb_pkg::ADDR_AIO, spb_pkg::PG1) |=> regs[spb_pkg::SEL_AIO2] == $past(req_i.wdata))
		else $error("second analog only not written on page 1");
	a_empty_read: assert property (@(posedge core_clk_i) disable iff (srst_i)
		req_i.rd && !req_i.wr && req_i.addr == spb_pkg::ADDR_AIO && page_number_field_o >= spb_pkg::PG2
		|=> rdata_o == spb_pkg::RST_ZERO)
		else $error("empty slot read nonzero");
	a_empty_write: assert property (@(posedge core_clk_i) disable iff (srst_i)
		s_wr_pg(spb_pkg::ADDR_TCTL, 4'hF) |=> $stable(regs[spb_pkg::SEL_P2MODE]) && $stable(regs[spb_pkg::SEL_TREN])
		&& $stable(regs[spb_pkg::SEL_TRLC]) && $stable(regs[spb_pkg::SEL_TSPC]))
		else $error("empty slot write changed a register");
	a_mode1_zero: assert property (@(posedge core_clk_i) disable iff (srst_i)
		s_wr_pg(spb_pkg::ADDR_MODE1, spb_pkg::PG0) |=> regs[spb_pkg::SEL_P0MODE] == $past(req_i.wdata))
		else $error("port zero mode not written on page 0");
	a_mode1_two: assert property (@(posedge core_clk_i) disable iff (srst_i)
		s_wr_pg(spb_pkg::ADDR_MODE1, spb_pkg::PG1) |=> regs[spb_pkg::SEL_T2M1] == ($past(req_i.wdata) & spb_pkg::MASK_MODE1))
		else $error("timer two mode one wrong on page 1");
	a_mode1_three: assert property (@(posedge core_clk_i) disable iff (srst_i)
		s_wr_pg(spb_pkg::ADDR_MODE1, spb_pkg::PG2) |=> regs[spb_pkg::SEL_T3M1] == ($past(req_i.wdata) & spb_pkg::MASK_MODE1))
		else $error("timer three mode one wrong on page 2");
	a_mode1_four: assert property (@(posedge core_clk_i) disable iff (srst_i)
		s_wr_pg(spb_pkg::ADDR_MODE1, spb_pkg::PG3) |=> regs[spb_pkg::SEL_T4M1] == ($past(req_i.wdata) & spb_pkg::MASK_MODE1_T4))
		else $error("timer four mode one wrong on page 3");
endmodule // spb_sfr_page_select_bank

// File: testbench/spb_core_model.sv
// Core-side register bus master model
module spb_core_model (
	input wire logic core_clk_i,
	input wire logic [7:0] rdata_i,
	output spb_pkg::spb_req_s req_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial req_o = '0;
	// One access, then bus released with scrambled address and data
	task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata, output logic [7:0] rdata);
		@(posedge core_clk_i);
		req_o <= '{wr: wr, rd: !wr, addr: addr, wdata: wdata};
		@(posedge core_clk_i);
		req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
		@(negedge core_clk_i);
		rdata = rdata_i;
	endtask
	// Page load before any paged access, reserved bits zero
	task automatic set_page(input logic [3:0] pg);
		logic [7:0] unused;
		access(1'b1, spb_pkg::ADDR_PAGE, {4'h0, pg}, unused);
	endtask
endmodule // spb_core_model

// File: testbench/spb_sfr_page_select_bank_tb.sv
// Self-checking bench for the paged register decoder
module spb_sfr_page_select_bank_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_i;
	logic srst_i;
	spb_pkg::spb_req_s req;
	logic [7:0] rdata;
	logic [7:0] p0_latch;
	logic [7:0] p1_latch;
	logic [7:0] sp;
	logic [7:0] tren;
	logic [3:0] page;
	int n_fail;
	int num_checks;
	spb_sfr_page_select_bank u_spb_sfr_page_select_bank (.core_clk_i(core_clk_i), .srst_i(srst_i), .req_i(req),
		.rdata_o(rdata), .page_number_field_o(page), .port_zero_latch_o(p0_latch),
		.port_one_latch_o(p1_latch), .stack_pointer_o(sp), .timer_run_enable_o(tren));
	spb_core_model u_spb_core_model (.core_clk_i(core_clk_i), .rdata_i(rdata), .req_o(req));
	// ---
	// Helpers
	// ---
	task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] pg, input logic [7:0] addr, input logic [7:0] data);
		logic [7:0] d;
		u_spb_core_model.set_page(pg);
		u_spb_core_model.access(1'b1, addr, data, d);
	endtask
	task automatic rd_chk(input string name, input logic [3:0] pg, input logic [7:0] addr, input logic [7:0] exp);
		logic [7:0] d;
		u_spb_core_model.set_page(pg);
		u_spb_core_model.access(1'b0, addr, 8'h00, d);
		chk8(name, exp, d);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// ---
	// Scenarios
	// ---
	task automatic t_reset_values();
		@(negedge core_clk_i);
		chk8("page_out", 8'h00, {4'h0, page});
		chk8("sp_out", 8'h07, sp);
		chk8("p0_out", 8'hFF, p0_latch);
		chk8("p1_out", 8'hFF, p1_latch);
		rd_chk("page_reg", 4'h0, 8'hAC, 8'h00);
		rd_chk("p0_reg", 4'h0, 8'h80, 8'hFF);
		rd_chk("p1_reg", 4'h0, 8'h90, 8'hFF);
		rd_chk("sp_reg", 4'h0, 8'h81, 8'h07);
		rd_chk("spctl", 4'h0, 8'h85, 8'h04);
		rd_chk("power_control_zero", 4'h0, 8'h87, 8'h10);
		rd_chk("system_flag_irq_enable", 4'h0, 8'h8E, 8'h60);
		rd_chk("rstev", 4'h0, 8'h97, 8'h00);
	endtask
	task automatic t_page_index();
		for (int i = 0; i < 16; i++) begin
			u_spb_core_model.set_page(i[3:0]);
			chk8("page_out", {4'h0, i[3:0]}, {4'h0, page});
		end
		rd_chk("page_reg", 4'hF, 8'hAC, 8'h0F);
		wr(4'hF, 8'h95, 8'h5A);
		rd_chk("empty_f95", 4'hF, 8'h95, 8'h00);
		rd_chk("unmapped_a9", 4'h0, 8'hA9, 8'h00);
	endtask
	task automatic t_timer_ctl();
		for (int i = 0; i < 4; i++) wr(i[3:0], 8'h95, 8'h50 + i[7:0]);
		chk8("tren_out", 8'h51, tren);
		for (int i = 0; i < 4; i++) rd_chk("reg95", i[3:0], 8'h95, 8'h50 + i[7:0]);
	endtask
	task automatic t_uart_ctl();
		for (int i = 0; i < 5; i++) wr(i[3:0], 8'h98, 8'hC0 + i[7:0]);
		for (int i = 0; i < 5; i++) rd_chk("reg98", i[3:0], 8'h98, (i == 1) ? 8'hC2 : 8'hC0 + i[7:0]);
		for (int i = 0; i < 5; i++) wr(i[3:0], 8'h99, 8'hA0 + i[7:0]);
		for (int i = 0; i < 5; i++) rd_chk("reg99", i[3:0], 8'h99, (i == 1) ? 8'hA2 : 8'hA0 + i[7:0]);
	endtask
	task automatic t_analog();
		for (int i = 0; i < 4; i++) wr(i[3:0], 8'h92, 8'h3C + i[7:0]);
		for (int i = 0; i < 4; i++) rd_chk("reg92", i[3:0], 8'h92, (i < 2) ? 8'h3C + i[7:0] : 8'h00);
	endtask
	task automatic t_mode_one();
		for (int i = 0; i < 4; i++) wr(i[3:0], 8'h93, 8'hFF);
		for (int i = 0; i < 4; i++) rd_chk("reg93", i[3:0], 8'h93, (i == 0) ? 8'hFF : (i == 3) ? 8'h9F : 8'h97);
	endtask
	task automatic t_absent_bits();
		wr(4'h0, 8'h8E, 8'hFF);
		rd_chk("system_flag_irq_enable_b3", 4'h0, 8'h8E, 8'hF7);
		wr(4'h0, 8'h97, 8'hFF);
		rd_chk("rstev_b3", 4'h0, 8'h97, 8'hF7);
	endtask
	task automatic t_mid_reset();
		wr(4'h3, 8'h80, 8'h3C);
		wr(4'h3, 8'h90, 8'hC3);
		wr(4'h3, 8'h81, 8'h55);
		chk8("p0_wr", 8'h3C, p0_latch);
		chk8("p1_wr", 8'hC3, p1_latch);
		chk8("sp_wr", 8'h55, sp);
		chk8("page_wr", 8'h03, {4'h0, page});
		@(posedge core_clk_i);
		srst_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		srst_i <= 1'b0;
		@(negedge core_clk_i);
		chk8("page_rst", 8'h00, {4'h0, page});
		chk8("sp_rst", 8'h07, sp);
		chk8("p0_rst", 8'hFF, p0_latch);
		chk8("p1_rst", 8'hFF, p1_latch);
		rd_chk("system_flag_irq_enable_rst", 4'h0, 8'h8E, 8'h60);
	endtask
	// ---
	// Clock, sequence, watchdog
	// ---
	initial begin
		core_clk_i = 1'b0;
		forever #20 core_clk_i = ~core_clk_i;
	end
	initial begin
		n_fail = 0;
		num_checks = 0;
		srst_i = 1'b1;
		repeat (5) @(posedge core_clk_i);
		srst_i <= 1'b0;
		t_reset_values();
		t_page_index();
		t_timer_ctl();
		t_uart_ctl();
		t_analog();
		t_mode_one();
		t_absent_bits();
		t_mid_reset();
		tally_and_finish();
	end
	initial begin
		#400000;
		n_fail++;
		tally_and_finish();
	end
endmodule // spb_sfr_page_select_bank_tb
